// >>> logic/dbgcap_ctrl.sv
// debug code capture controller: timestamp timer, entry queue, register port
`timescale 1ns/1ps

module dbgcap_fifo #(
   parameter int unsigned WIDTH = dbgcap_pkg::DATA_W,
   parameter int unsigned DEPTH = dbgcap_pkg::DEPTH,
   parameter int unsigned PTR_W = dbgcap_pkg::PTR_W,
   parameter int unsigned CNT_W = dbgcap_pkg::CNT_W
) (
   input  wire logic             mclk_i,
   input  wire logic             reset_n_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  full_o,
   output logic      [CNT_W-1:0] count_o
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wp;
      logic [PTR_W-1:0]            rp;
      logic [CNT_W-1:0]            cnt;
   } dbgcap_fifo_st_t;

   dbgcap_fifo_st_t s_q;
   dbgcap_fifo_st_t s_d;
   logic            push;
   logic            pop;

   assign full_o      = (s_q.cnt == CNT_W'(DEPTH));
   assign out_valid_o = (s_q.cnt != '0);
   // a pop in the same cycle frees the slot, so a full queue can still take a word
   assign in_ready_o  = !full_o || out_ready_i;
   assign out_data_o  = s_q.mem[s_q.rp];
   assign count_o     = s_q.cnt;
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      s_d = s_q;
      if (flush_i) begin
         s_d.wp  = '0;
         s_d.rp  = '0;
         s_d.cnt = '0;
      end else begin
         if (push) begin
            s_d.mem[s_q.wp] = in_data_i;
            s_d.wp          = s_q.wp + PTR_W'(1);
         end
         if (pop) begin
            s_d.rp = s_q.rp + PTR_W'(1);
         end
         s_d.cnt = s_q.cnt + CNT_W'(push) - CNT_W'(pop);
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

module dbgcap_ctrl (
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        activate_i,
   input  wire logic        host_wr_i,
   input  wire logic [7:0]  host_data_i,
   output logic             host_claim_o,
   input  wire logic [11:0] ec_addr_i,
   input  wire logic        ec_wr_i,
   input  wire logic        ec_rd_i,
   input  wire logic [31:0] ec_wdata_i,
   output logic      [31:0] ec_rdata_o,
   output logic             capture_irq_o
);
   typedef struct packed {
      logic [1:0]                       thr;
      logic                             run;
      logic [1:0]                       rate;
      logic [dbgcap_pkg::STAMP_W-1:0]   entry_stamp;
      logic [dbgcap_pkg::PRE_W-1:0]     presc;
      logic                             overrun;
      logic [31:0]                      rdata;
   } dbgcap_st_t;

   dbgcap_st_t                      s_q;
   dbgcap_st_t                      s_d;
   logic                            wr_cfg;
   logic                            wr_cnt;
   logic                            rd_queue;
   logic                            flush;
   logic                            host_push;
   logic                            ec_pop;
   logic                            drop_old;
   logic                            tick;
   logic                            fifo_in_ready;
   logic                            fifo_out_valid;
   logic                            fifo_full;
   logic [31:0]                     fifo_head;
   logic [dbgcap_pkg::CNT_W-1:0]    fifo_count;
   logic [31:0]                     entry_word;

   assign wr_cfg    = ec_wr_i && (ec_addr_i == dbgcap_pkg::OFS_CONFIG);
   assign wr_cnt    = ec_wr_i && (ec_addr_i == dbgcap_pkg::OFS_COUNT);
   assign rd_queue  = ec_rd_i && (ec_addr_i == dbgcap_pkg::OFS_QUEUE);
   assign host_claim_o = activate_i;
   assign host_push = host_wr_i && activate_i;
   assign ec_pop    = rd_queue && fifo_out_valid;
   assign drop_old  = host_push && fifo_full && !ec_pop;
   assign flush     = (wr_cfg && ec_wdata_i[dbgcap_pkg::CFG_FLUSH_BIT]) || !activate_i;
   assign entry_word = {s_q.entry_stamp, host_data_i};
   // a rate change below the running count ticks at once instead of wrapping the prescaler
   assign tick = activate_i && s_q.run && (s_q.presc >= dbgcap_pkg::div_last(s_q.rate));
   assign capture_irq_o = activate_i && (fifo_count >= dbgcap_pkg::thr_level(s_q.thr));
   assign ec_rdata_o = s_q.rdata;

   dbgcap_fifo u_fifo (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .flush_i     (flush),
      .in_valid_i  (host_push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (entry_word),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (ec_pop || drop_old),
      .out_data_o  (fifo_head),
      .full_o      (fifo_full),
      .count_o     (fifo_count)
   );

   always_comb begin
      s_d = s_q;
      if (wr_cfg) begin
         s_d.thr  = ec_wdata_i[dbgcap_pkg::CFG_THR_LSB +: 2];
         s_d.run  = ec_wdata_i[dbgcap_pkg::CFG_RUN_BIT];
         s_d.rate = ec_wdata_i[dbgcap_pkg::CFG_RATE_LSB +: 2];
      end
      // prescaler restarts whenever counting is off
      if (!activate_i || !s_q.run || tick) begin
         s_d.presc = dbgcap_pkg::PRE_RST;
      end else begin
         s_d.presc = s_q.presc + dbgcap_pkg::PRE_W'(1);
      end
      if (!activate_i) begin
         s_d.entry_stamp = dbgcap_pkg::STAMP_RST;
      end else if (wr_cfg && ec_wdata_i[dbgcap_pkg::CFG_CLR_BIT]) begin
         s_d.entry_stamp = dbgcap_pkg::STAMP_RST;
      end else if (wr_cnt) begin
         s_d.entry_stamp = ec_wdata_i[31:dbgcap_pkg::CNT_LSB];
      end else if (tick) begin
         s_d.entry_stamp = s_q.entry_stamp + dbgcap_pkg::STAMP_W'(1);
      end
      // overflow is sticky; a fresh overrun wins over the flush that clears it
      if (host_push && fifo_full) begin
         s_d.overrun = 1'b1;
      end else if (flush) begin
         s_d.overrun = 1'b0;
      end
      s_d.rdata = 32'h00000000;
      if (ec_rd_i) begin
         if (ec_addr_i == dbgcap_pkg::OFS_QUEUE) begin
            if (fifo_out_valid) begin
               s_d.rdata = fifo_head;
            end
         end else if (ec_addr_i == dbgcap_pkg::OFS_CONFIG) begin
            s_d.rdata[dbgcap_pkg::CFG_THR_LSB +: 2]  = s_q.thr;
            s_d.rdata[dbgcap_pkg::CFG_RUN_BIT]       = s_q.run;
            s_d.rdata[dbgcap_pkg::CFG_RATE_LSB +: 2] = s_q.rate;
         end else if (ec_addr_i == dbgcap_pkg::OFS_STATUS) begin
            s_d.rdata[dbgcap_pkg::ST_OVR_BIT] = s_q.overrun;
            s_d.rdata[dbgcap_pkg::ST_NE_BIT]  = fifo_out_valid;
         end else if (ec_addr_i == dbgcap_pkg::OFS_COUNT) begin
            s_d.rdata[31:dbgcap_pkg::CNT_LSB] = s_q.entry_stamp;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q             <= '0;
         s_q.thr         <= dbgcap_pkg::THR_RST;
         s_q.run         <= dbgcap_pkg::RUN_RST;
         s_q.rate        <= dbgcap_pkg::RATE_RST;
         s_q.entry_stamp <= dbgcap_pkg::STAMP_RST;
         s_q.presc       <= dbgcap_pkg::PRE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   sequence seq_quiet;
      !wr_cfg && !wr_cnt && activate_i;
   endsequence

   sequence seq_full_write;
      host_push && fifo_full && !ec_pop && !flush;
   endsequence

   AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      capture_irq_o == (activate_i && fifo_count >= ((s_q.thr == 2'h0) ? 5'h01 : (s_q.thr == 2'h1) ? 5'h04
                                                   : (s_q.thr == 2'h2) ? 5'h08 : 5'h0E)))
      else $error("capture interrupt does not match fill level");

   AST_STOP_HOLDS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (seq_quiet and !s_q.run) |=> $stable(s_q.entry_stamp))
      else $error("counter moved while stopped");

   AST_RATE8: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (s_q.run && s_q.rate == 2'h0 && s_q.presc == 6'h00) ##0 seq_quiet [*8]
      |=> s_q.entry_stamp == $past(s_q.entry_stamp, 8) + 24'h000001)
      else $error("divide by eight rate wrong");

   AST_CLEAR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (wr_cfg && ec_wdata_i[dbgcap_pkg::CFG_CLR_BIT]) |=> s_q.entry_stamp == 24'h000000)
      else $error("timestamp clear failed");

   AST_LOAD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (wr_cnt && activate_i && !(wr_cfg && ec_wdata_i[dbgcap_pkg::CFG_CLR_BIT]))
      |=> s_q.entry_stamp == $past(ec_wdata_i[31:8]))
      else $error("counter load failed");

   AST_FLUSH: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      flush |=> fifo_count == 5'h00)
      else $error("queue not emptied by discard");

   AST_OVERRUN: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      seq_full_write |=> s_q.overrun && fifo_count == 5'h10)
      else $error("overrun not flagged or level changed");

   AST_INACTIVE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !activate_i |=> s_q.entry_stamp == 24'h000000 && fifo_count == 5'h00 && !capture_irq_o)
      else $error("disabled block not cleared");

   AST_STROBE_READ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ec_rd_i && ec_addr_i == dbgcap_pkg::OFS_CONFIG) |=> ec_rdata_o[2:1] == 2'h0)
      else $error("strobe bits read nonzero");

   AST_POP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ec_pop && !drop_old && !flush) |=> ec_rdata_o == $past(fifo_head)
      && fifo_count == $past(fifo_count) - 5'h01 + 5'($past(host_push)))
      else $error("queue read wrong word or level");

   AST_NOT_EMPTY: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ec_rd_i && ec_addr_i == dbgcap_pkg::OFS_STATUS) |=> ec_rdata_o[0] == ($past(fifo_count) != 5'h00))
      else $error("non-empty bit wrong");
endmodule

// >>> logic/dbgcap_pkg.sv
// constants and shared helpers for the debug code capture controller
// Function
// - threshold code picks 1, 4, 8, 14 entries
// - run bit one counts, zero holds
// - rate code divides clock 8/16/32/64
// - clear bit one zeroes timestamp counter
// - writing zero to counter clears it
// - discard bit one empties the queue
// - clear and discard bits read zero
// - host write to full queue sets overflow
// - non-empty bit follows queue occupancy
// - counter register write loads the counter
// - counter read gives value in bits 31:8
// - host byte plus timestamp pushed as entry
// - full queue drops oldest on host write
// - interrupt while enabled and level reaches threshold
// - disabled: unclaimed, flushed, counter zero, stopped
package dbgcap_pkg;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned DEPTH   = 16;
   localparam int unsigned PTR_W   = 4;
   localparam int unsigned CNT_W   = 5;
   localparam int unsigned STAMP_W = 24;
   localparam int unsigned PRE_W   = 6;
   localparam int unsigned ADDR_W  = 12;

   localparam logic [11:0] OFS_QUEUE  = 12'h100;
   localparam logic [11:0] OFS_CONFIG = 12'h104;
   localparam logic [11:0] OFS_STATUS = 12'h108;
   localparam logic [11:0] OFS_COUNT  = 12'h10C;

   localparam int unsigned CFG_THR_LSB   = 6;
   localparam int unsigned CFG_RUN_BIT   = 5;
   localparam int unsigned CFG_RATE_LSB  = 3;
   localparam int unsigned CFG_CLR_BIT   = 2;
   localparam int unsigned CFG_FLUSH_BIT = 1;
   localparam int unsigned ST_OVR_BIT    = 1;
   localparam int unsigned ST_NE_BIT     = 0;
   localparam int unsigned CNT_LSB       = 8;

   localparam logic [1:0]         THR_RST   = 2'h0;
   localparam logic               RUN_RST   = 1'b0;
   localparam logic [1:0]         RATE_RST  = 2'h0;
   localparam logic [STAMP_W-1:0] STAMP_RST = 24'h000000;
   localparam logic [PRE_W-1:0]   PRE_RST   = 6'h00;

   localparam logic [CNT_W-1:0] THR_LVL0 = 5'h01;
   localparam logic [CNT_W-1:0] THR_LVL1 = 5'h04;
   localparam logic [CNT_W-1:0] THR_LVL2 = 5'h08;
   localparam logic [CNT_W-1:0] THR_LVL3 = 5'h0E;

   // last prescaler value before a tick, i.e. divisor minus one
   localparam logic [PRE_W-1:0] DIV0_LAST = 6'h07;
   localparam logic [PRE_W-1:0] DIV1_LAST = 6'h0F;
   localparam logic [PRE_W-1:0] DIV2_LAST = 6'h1F;
   localparam logic [PRE_W-1:0] DIV3_LAST = 6'h3F;

   function automatic logic [CNT_W-1:0] thr_level(input logic [1:0] code);
      case (code)
         2'h0:    thr_level = THR_LVL0;
         2'h1:    thr_level = THR_LVL1;
         2'h2:    thr_level = THR_LVL2;
         default: thr_level = THR_LVL3;
      endcase
   endfunction

   function automatic logic [PRE_W-1:0] div_last(input logic [1:0] code);
      case (code)
         2'h0:    div_last = DIV0_LAST;
         2'h1:    div_last = DIV1_LAST;
         2'h2:    div_last = DIV2_LAST;
         default: div_last = DIV3_LAST;
      endcase
   endfunction
endpackage

// >>> testbench/dbgcap_host_model.sv
// host bus writer model that posts debug code bytes to the capture port
`timescale 1ns/1ps

module dbgcap_host_model (
   input  wire logic       mclk_i,
   output logic            host_wr_o,
   output logic      [7:0] host_data_o
);
   initial begin
      host_wr_o   = 1'b0;
      host_data_o = 8'h00;
   end

   // one-cycle strobe per byte; data is inverted once released so nothing stale looks valid
   task automatic push(input logic [7:0] b);
      @(negedge mclk_i);
      host_wr_o   = 1'b1;
      host_data_o = b;
      @(negedge mclk_i);
      host_wr_o   = 1'b0;
      host_data_o = ~b;
   endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the debug code capture controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end

module testbench;
   logic        mclk_i    = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        act       = 1'b0;
   logic        host_wr;
   logic [7:0]  host_data;
   logic        host_claim;
   logic [11:0] ec_addr   = 12'h000;
   logic        ec_wr     = 1'b0;
   logic        ec_rd     = 1'b0;
   logic [31:0] ec_wdata  = 32'h00000000;
   logic [31:0] ec_rdata;
   logic        irq;
   logic [31:0] rd;
   int          fail_count = 0;
   int          n_checks   = 0;

   always #50 mclk_i = ~mclk_i;

   dbgcap_host_model host (
      .mclk_i      (mclk_i),
      .host_wr_o   (host_wr),
      .host_data_o (host_data)
   );

   dbgcap_ctrl DUT (
      .mclk_i        (mclk_i),
      .reset_n_i     (reset_n_i),
      .activate_i    (act),
      .host_wr_i     (host_wr),
      .host_data_i   (host_data),
      .host_claim_o  (host_claim),
      .ec_addr_i     (ec_addr),
      .ec_wr_i       (ec_wr),
      .ec_rd_i       (ec_rd),
      .ec_wdata_i    (ec_wdata),
      .ec_rdata_o    (ec_rdata),
      .capture_irq_o (irq)
   );

   task automatic stop_test();
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge mclk_i);
      ec_addr  = a;
      ec_wdata = d;
      ec_wr    = 1'b1;
      @(negedge mclk_i);
      ec_wr    = 1'b0;
      ec_wdata = ~d;
   endtask

   // read data stands in the cycle after the read edge
   task automatic rdr(input logic [11:0] a, output logic [31:0] d);
      @(negedge mclk_i);
      ec_addr = a;
      ec_rd   = 1'b1;
      @(negedge mclk_i);
      ec_rd   = 1'b0;
      d       = ec_rdata;
   endtask

   task automatic chk_rd(input string n, input logic [11:0] a, input logic [31:0] e);
      rdr(a, rd);
      `CHK(n, e, rd)
   endtask

   task automatic t_reset();
      chk_rd("config", 12'h104, 32'h00000000);
      chk_rd("status", 12'h108, 32'h00000000);
      chk_rd("count", 12'h10C, 32'h00000000);
      chk_rd("empty pop", 12'h100, 32'h00000000);
      chk_rd("unmapped", 12'h200, 32'h00000000);
   endtask

   task automatic t_stamp();
      wr(12'h10C, 32'h123456FF);
      chk_rd("count", 12'h10C, 32'h12345600);
      host.push(8'hA5);
      chk_rd("nonempty", 12'h108, 32'h00000001);
      chk_rd("entry", 12'h100, 32'h123456A5);
      chk_rd("empty", 12'h108, 32'h00000000);
   endtask

   task automatic t_rate();
      logic [31:0] a;
      logic [31:0] b;
      for (int r = 0; r < 4; r++) begin
         wr(12'h104, (32'(r) << 3) | 32'h00000020);
         rdr(12'h10C, a);
         // read edges sit exactly sixteen divisor periods apart
         repeat ((128 << r) - 2) @(negedge mclk_i);
         rdr(12'h10C, b);
         `CHK("rate", 32'h00001000, b - a)
      end
      wr(12'h104, 32'h00000000);
      rdr(12'h10C, a);
      repeat (100) @(negedge mclk_i);
      chk_rd("hold", 12'h10C, a);
      wr(12'h104, 32'h00000004);
      chk_rd("clear", 12'h10C, 32'h00000000);
      wr(12'h10C, 32'h00050000);
      wr(12'h104, 32'h00000000);
      chk_rd("noclear", 12'h10C, 32'h00050000);
      wr(12'h10C, 32'h00000000);
      chk_rd("zero load", 12'h10C, 32'h00000000);
      wr(12'h104, 32'h000000FF);
      chk_rd("wo bits", 12'h104, 32'h000000F8);
      wr(12'h104, 32'h00000000);
   endtask

   task automatic t_overflow();
      wr(12'h10C, 32'h00AB0000);
      for (int i = 0; i < 16; i++) host.push(8'(i));
      chk_rd("full", 12'h108, 32'h00000001);
      host.push(8'h10);
      chk_rd("overrun", 12'h108, 32'h00000003);
      chk_rd("oldest", 12'h100, 32'h00AB0001);
      wr(12'h104, 32'h00000002);
      chk_rd("flushed", 12'h108, 32'h00000000);
      host.push(8'h5A);
      wr(12'h104, 32'h00000000);
      chk_rd("noflush", 12'h108, 32'h00000001);
   endtask

   task automatic t_irq();
      int lv;
      for (int c = 0; c < 4; c++) begin
         lv = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 14;
         wr(12'h104, (32'(c) << 6) | 32'h00000002);
         for (int i = 1; i < lv; i++) host.push(8'(i));
         `CHK("irq low", 1'b0, irq)
         host.push(8'hEE);
         `CHK("irq high", 1'b1, irq)
      end
   endtask

   task automatic t_disable();
      `CHK("claim", 1'b1, host_claim)
      wr(12'h104, 32'h000000E8);
      act = 1'b0;
      host.push(8'h77);
      `CHK("claim off", 1'b0, host_claim)
      `CHK("irq off", 1'b0, irq)
      chk_rd("dropped", 12'h108, 32'h00000000);
      chk_rd("count off", 12'h10C, 32'h00000000);
      chk_rd("cfg kept", 12'h104, 32'h000000E8);
   endtask

   initial begin
      repeat (3) @(negedge mclk_i);
      reset_n_i = 1'b1;
      t_reset();
      act = 1'b1;
      t_stamp();
      t_rate();
      t_overflow();
      t_irq();
      t_disable();
      stop_test();
   end

   // guard against a hang anywhere in the sequence
   initial begin
      #2000000;
      fail_count++;
      stop_test();
   end
endmodule
